// file: rtl/ics_pkg.sv
// ics_pkg: constants and types of the internal configuration sequencer.
// assumes a 100 MHz internal oscillator drives the whole sequencer.
package ics_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int POR_DELAY_NS  = 1000;
    localparam int ERR_HOLD_NS   = 500;
    localparam int INIT_CYCLES   = 64;
    // least times round up
    localparam int POR_CYCLES  = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERR_CYCLES  = (ERR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W       = 8;

    // ------------------------------------------------------------
    // flash image layout
    // ------------------------------------------------------------
    localparam int HDR_ADDR    = 0;
    localparam int LEN_LSB     = 0;
    localparam int LEN_W       = 16;
    localparam int RUN_FLAG    = 31;
    localparam int RUN_LSB     = 16;
    localparam int RUN_W       = 15;
    localparam int DATA_LSB    = 0;
    localparam int DATA_W      = 16;
    localparam int FADDR_W     = 16;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_POR     = 9'h001,
        ST_HOLD    = 9'h002,
        ST_HDR     = 9'h004,
        ST_LOAD    = 9'h008,
        ST_DRAIN   = 9'h010,
        ST_RELEASE = 9'h020,
        ST_ERR     = 9'h040,
        ST_INIT    = 9'h080,
        ST_USER    = 9'h100
    } ics_state_t;

    typedef enum logic [1:0] {
        IO_TRISTATE = 2'h0,
        IO_PULLUP   = 2'h1,
        IO_USER     = 2'h2
    } ics_io_mode_t;

    typedef struct packed {
        logic [LEN_W-1:0]  addr;
        logic [DATA_W-1:0] data;
    } ics_config_ram_wr_t;

    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

endpackage : ics_pkg

// file: rtl/ics_buf2.sv
// ics_buf2: two-entry buffer between the decompressor and config_ram.
// assumes the sink may hold out_ready low for any number of cycles.
`timescale 1ns/1ps
module ics_buf2
    import ics_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // filling side
    input  wire logic         in_valid,
    output      logic         in_ready,
    input  wire ics_config_ram_wr_t in_data,
    // draining side
    output      logic         out_valid,
    input  wire logic         out_ready,
    output      ics_config_ram_wr_t out_data,
    // state
    output      logic         empty
);
    logic         out_valid_r;
    logic         skid_valid_r;
    ics_config_ram_wr_t out_data_r;
    ics_config_ram_wr_t skid_data_r;

    wire out_free = !out_valid_r || out_ready;
    wire in_take  = in_valid && !skid_valid_r;

    assign in_ready  = !skid_valid_r;
    assign out_valid = out_valid_r;
    assign out_data  = out_data_r;
    assign empty     = !out_valid_r && !skid_valid_r;

    // skid word goes first so order is kept under stall
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_valid_r  <= 1'b0;
            skid_valid_r <= 1'b0;
            out_data_r   <= '0;
            skid_data_r  <= '0;
        end else if (out_free) begin
            out_valid_r  <= skid_valid_r || in_take;
            out_data_r   <= skid_valid_r ? skid_data_r : in_data;
            skid_valid_r <= 1'b0;
        end else if (in_take) begin
            skid_valid_r <= 1'b1;
            skid_data_r  <= in_data;
        end
    end

endmodule : ics_buf2

// file: rtl/ics_sequencer.sv
// ics_sequencer: power-on / reconfiguration sequencer. reads the image from
// config_flash, expands runs on the fly and writes config_ram, then runs
// initialization and enters user mode.
// assumes flash answers on clk; pins arrive asynchronously.
//
// How it works
// - a held-low reconfiguration request restarts the whole configuration sequence
// - while request is low, status and done are pulled low, I/O per io_config_bits
// - after power-up, wait the power-on delay then start configuration
// - configuration fetches words from config_flash and writes config_ram
// - compressed runs are expanded while loading, no separate pass
// - with auto-restart on, an error restarts configuration by itself
// - with auto-restart off, error holds status low until a request
// - initialization starts only after the done line reads high
// - initialization is clocked by the internal oscillator for fixed cycles
// - after initialization, user mode starts and user I/O is handed over
// - dual-purpose pins keep configuration role until user mode, then as selected
`timescale 1ns/1ps
module ics_sequencer
    import ics_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // external handshake pins
    input  wire logic               reconfig_req_n,
    input  wire logic               status_in,
    output      logic               status_out,
    output      logic               status_oe,
    input  wire logic               done_in,
    output      logic               done_out,
    output      logic               done_oe,
    // options
    input  wire logic               auto_restart_en,
    input  wire logic               compress_en,
    input  wire logic               io_config_bits,
    input  wire logic               pin_user_sel,
    // config_flash read port
    output      logic               flash_rd,
    output      logic [FADDR_W-1:0] flash_addr,
    input  wire logic               flash_rvalid,
    input  wire logic               flash_err,
    input  wire logic [31:0]        flash_rdata,
    // config_ram write port
    output      logic               config_ram_we,
    output      ics_config_ram_wr_t       config_ram_wr,
    input  wire logic               config_ram_ready,
    // device mode
    output      ics_io_mode_t       io_mode,
    output      logic               pin_user_en,
    output      logic               user_mode,
    output      logic               config_error
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] req_sync_r;
    logic [2:0] done_sync_r;
    logic       req_ok_r;
    logic       done_high_r;

    // change counts once stages 2 and 3 agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            req_sync_r  <= 3'h7;
            done_sync_r <= 3'h0;
            req_ok_r    <= 1'b1;
            done_high_r <= 1'b0;
        end else begin
            req_sync_r  <= {req_sync_r[1:0], reconfig_req_n};
            done_sync_r <= {done_sync_r[1:0], done_in};
            if (req_sync_r[1] == req_sync_r[2])
                req_ok_r <= req_sync_r[2];
            if (done_sync_r[1] == done_sync_r[2])
                done_high_r <= done_sync_r[2];
        end
    end

    // ------------------------------------------------------------
    // state and load registers
    // ------------------------------------------------------------
    ics_state_t         state_r, state_nxt;
    logic [CNT_W-1:0]   cnt_r, cnt_nxt;
    logic               flash_rd_r;
    logic [FADDR_W-1:0] flash_addr_r;
    logic               tok_valid_r;
    logic [RUN_W-1:0]   run_left_r;
    logic [DATA_W-1:0]  tok_data_r;
    logic [LEN_W-1:0]   remain_r;
    logic [LEN_W-1:0]   wr_addr_r;
    logic               buf_in_ready;
    logic               buf_empty;
    logic               buf_out_valid;
    ics_config_ram_wr_t       buf_out_data;

    wire st_por  = (state_r == ST_POR);
    wire st_hdr  = (state_r == ST_HDR);
    wire st_load = (state_r == ST_LOAD);
    wire st_err  = (state_r == ST_ERR);
    wire st_init = (state_r == ST_INIT);
    wire st_hold = (state_r == ST_HOLD);

    // ------------------------------------------------------------
    // fetch and expand decode
    // ------------------------------------------------------------
    wire [LEN_W-1:0] hdr_len  = flash_rdata[LEN_LSB +: LEN_W];
    wire             tok_run  = flash_rdata[RUN_FLAG];
    wire [RUN_W-1:0] tok_cnt  = flash_rdata[RUN_LSB +: RUN_W];
    wire [LEN_W-1:0] tok_need = {1'b0, tok_cnt} + 16'h0001;
    wire             hdr_bad  = flash_err || (hdr_len == 16'h0000);
    // a run must fit what is left of the image
    wire tok_bad = flash_err || (tok_run && !compress_en)
                || (tok_run && (tok_need > remain_r));
    wire got_hdr  = st_hdr && flash_rvalid && flash_rd_r;
    wire got_tok  = st_load && flash_rvalid && flash_rd_r;
    wire push     = st_load && tok_valid_r && buf_in_ready;
    wire last_push = push && (remain_r == 16'h0001);
    wire want_rd  = st_hdr || (st_load && !tok_valid_r && !got_tok);
    wire count_done = (cnt_r == CNT_ZERO);

    function automatic logic [CNT_W-1:0] load_count(input ics_state_t s);
        case (s)
            ST_POR:  load_count = CNT_W'(POR_CYCLES);
            ST_ERR:  load_count = CNT_W'(ERR_CYCLES);
            ST_INIT: load_count = CNT_W'(INIT_CYCLES);
            default: load_count = CNT_ZERO;
        endcase
    endfunction : load_count

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_POR:     if (count_done) state_nxt = ST_HDR;
            ST_HOLD:    state_nxt = ST_POR;
            ST_HDR:     if (got_hdr) state_nxt = hdr_bad ? ST_ERR : ST_LOAD;
            ST_LOAD: begin
                if (got_tok && tok_bad)
                    state_nxt = ST_ERR;
                else if (last_push)
                    state_nxt = ST_DRAIN;
            end
            ST_DRAIN:   if (buf_empty) state_nxt = ST_RELEASE;
            ST_RELEASE: if (done_high_r) state_nxt = ST_INIT;
            ST_ERR:     if (auto_restart_en && count_done) state_nxt = ST_POR;
            ST_INIT:    if (count_done) state_nxt = ST_USER;
            ST_USER:    state_nxt = ST_USER;
            default:    state_nxt = ST_POR;
        endcase
        // request overrides every state and holds there
        if (!req_ok_r)
            state_nxt = ST_HOLD;
    end

    assign cnt_nxt = (state_nxt != state_r) ? load_count(state_nxt)
                   : (count_done ? CNT_ZERO : cnt_r - 8'h01);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_POR;
            cnt_r   <= CNT_W'(POR_CYCLES);
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // flash fetch
    // ------------------------------------------------------------
    wire in_cfg_nxt = (state_nxt == ST_HDR) || (state_nxt == ST_LOAD);
    wire fetch_done = flash_rd_r && flash_rvalid;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flash_rd_r   <= 1'b0;
            flash_addr_r <= '0;
        end else begin
            flash_rd_r <= in_cfg_nxt && want_rd && !fetch_done;
            if (state_nxt == ST_POR || state_nxt == ST_HOLD)
                flash_addr_r <= FADDR_W'(HDR_ADDR);
            else if (fetch_done)
                flash_addr_r <= flash_addr_r + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // run expansion, written straight into the buffer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tok_valid_r <= 1'b0;
            run_left_r  <= '0;
            tok_data_r  <= '0;
        end else if (got_tok && !tok_bad) begin
            tok_valid_r <= 1'b1;
            run_left_r  <= tok_run ? tok_cnt : '0;
            tok_data_r  <= flash_rdata[DATA_LSB +: DATA_W];
        end else if (push) begin
            tok_valid_r <= (run_left_r != '0);
            run_left_r  <= (run_left_r != '0) ? run_left_r - 15'h0001 : '0;
        end else if (!st_load) begin
            tok_valid_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            remain_r  <= '0;
            wr_addr_r <= '0;
        end else if (got_hdr) begin
            remain_r  <= hdr_len;
            wr_addr_r <= '0;
        end else if (push) begin
            remain_r  <= remain_r - 16'h0001;
            wr_addr_r <= wr_addr_r + 16'h0001;
        end
    end

    // stall by config_ram reaches the expander through in_ready
    ics_buf2 u_buf (
        .clk       (clk),
        .resetn    (resetn),
        .in_valid  (push),
        .in_ready  (buf_in_ready),
        .in_data   ({wr_addr_r, tok_data_r}),
        .out_valid (buf_out_valid),
        .out_ready (config_ram_ready),
        .out_data  (buf_out_data),
        .empty     (buf_empty)
    );

    // ------------------------------------------------------------
    // pins and mode outputs
    // ------------------------------------------------------------
    logic         status_oe_r;
    logic         done_oe_r;
    logic         user_mode_r;
    logic         pin_user_r;
    logic         cfg_err_r;
    ics_io_mode_t io_mode_r;

    wire pull_status = (state_nxt == ST_HOLD) || (state_nxt == ST_POR)
                    || (state_nxt == ST_ERR);
    wire release_done = (state_nxt == ST_RELEASE) || (state_nxt == ST_INIT)
                     || (state_nxt == ST_USER);
    wire user_nxt = (state_nxt == ST_USER);
    wire ics_io_mode_t io_nxt = user_nxt ? IO_USER
                              : (io_config_bits ? IO_PULLUP : IO_TRISTATE);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_oe_r <= 1'b1;
            done_oe_r   <= 1'b1;
            user_mode_r <= 1'b0;
            pin_user_r  <= 1'b0;
            cfg_err_r   <= 1'b0;
            io_mode_r   <= IO_TRISTATE;
        end else begin
            status_oe_r <= pull_status;
            done_oe_r   <= !release_done;
            user_mode_r <= user_nxt;
            pin_user_r  <= user_nxt && pin_user_sel;
            cfg_err_r   <= (state_nxt == ST_ERR);
            io_mode_r   <= io_nxt;
        end
    end

    // open drain: only ever pulls low
    assign status_out   = 1'b0;
    assign done_out     = 1'b0;
    assign status_oe    = status_oe_r;
    assign done_oe      = done_oe_r;
    assign flash_rd     = flash_rd_r;
    assign flash_addr   = flash_addr_r;
    assign config_ram_we      = buf_out_valid;
    assign config_ram_wr      = buf_out_data;
    assign io_mode      = io_mode_r;
    assign pin_user_en  = pin_user_r;
    assign user_mode    = user_mode_r;
    assign config_error = cfg_err_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_req_restarts: assert property (!req_ok_r |=> st_hold)
        else $error("request did not restart sequence");
    a_hold_pulls_low: assert property (st_hold |-> status_oe && done_oe
        && io_mode_r != IO_USER)
        else $error("pins not pulled low in hold");
    a_por_to_cfg: assert property ($rose(st_por) && req_ok_r
        |-> cnt_r == CNT_W'(POR_CYCLES))
        else $error("power-on delay length wrong");
    a_fetch_in_cfg: assert property (flash_rd_r |-> st_hdr || st_load)
        else $error("flash read outside configuration");
    a_run_expands: assert property (push && run_left_r != '0 && req_ok_r
        |=> tok_valid_r)
        else $error("run dropped before expanded");
    a_auto_restart: assert property (st_err && auto_restart_en && count_done
        && req_ok_r |=> st_por)
        else $error("no automatic restart after error");
    a_err_holds: assert property (st_err && !auto_restart_en && req_ok_r
        |=> st_err && status_oe && config_error)
        else $error("error not held on status line");
    a_init_after_done: assert property ($rose(st_init) |-> $past(done_high_r)
        && !done_oe)
        else $error("init began before done high");
    a_init_length: assert property ($rose(st_init) |-> cnt_r ==
        CNT_W'(INIT_CYCLES))
        else $error("init cycle count wrong");
    a_user_handover: assert property (user_mode |-> io_mode == IO_USER)
        else $error("user mode without user I/O");
    a_pin_role: assert property (!user_mode |-> !pin_user_en)
        else $error("pin left config role early");
    a_done_after_load: assert property ($fell(done_oe) |-> remain_r == '0
        && buf_empty && !config_error)
        else $error("done released before image written");

    c_user_mode: cover property ($rose(user_mode));
    c_error_seen: cover property ($rose(config_error));
    c_run_stall: cover property (push && run_left_r != '0 ##1 !buf_in_ready);
    c_reconfig: cover property (user_mode ##1 st_hold);

endmodule : ics_sequencer

// file: verification/ics_partner.sv
// ics_partner: config_flash read model and config_ram write sink.
// assumes the sequencer holds flash_rd and config_ram_we until answered.
`timescale 1ns/1ps
module ics_partner
    import ics_pkg::*;
(
    // clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // config_flash side
    input  wire logic               flash_rd,
    input  wire logic [FADDR_W-1:0] flash_addr,
    output      logic               flash_rvalid,
    output      logic               flash_err,
    output      logic [31:0]        flash_rdata,
    // config_ram side
    input  wire logic               config_ram_we,
    input  wire ics_config_ram_wr_t       config_ram_wr,
    output      logic               config_ram_ready,
    // behaviour knobs
    input  wire logic [3:0]         lat,
    input  wire logic               stall_en,
    input  wire logic               err_arm
);
    logic [31:0] mem [0:63];
    logic [15:0] ram [0:63];
    int          wr_cnt;
    logic [3:0]  wait_r;
    logic [1:0]  phase_r;

    // ------------------------------------------------------------
    // flash: answer after lat idle cycles, data garbled when idle
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flash_rvalid <= 1'b0;
            flash_err    <= 1'b0;
            flash_rdata  <= 32'h0;
            wait_r       <= 4'h0;
        end else if (flash_rvalid) begin
            flash_rvalid <= 1'b0;
            flash_err    <= 1'b0;
            flash_rdata  <= ~flash_rdata;
        end else if (flash_rd && wait_r == lat) begin
            flash_rvalid <= 1'b1;
            flash_rdata  <= mem[flash_addr[5:0]];
            // fault injected on the first token only
            flash_err    <= err_arm && flash_addr == 16'h0001;
            wait_r       <= 4'h0;
        end else begin
            flash_rdata  <= ~flash_rdata;
            wait_r       <= flash_rd ? wait_r + 4'h1 : 4'h0;
        end
    end

    // ------------------------------------------------------------
    // config_ram: stalls three cycles of four when asked
    // ------------------------------------------------------------
    assign config_ram_ready = !stall_en || phase_r == 2'h0;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_r <= 2'h0;
            wr_cnt  <= 0;
        end else begin
            phase_r <= phase_r + 2'h1;
            if (config_ram_we && config_ram_ready) begin
                ram[config_ram_wr.addr[5:0]] <= config_ram_wr.data;
                wr_cnt                 <= wr_cnt + 1;
            end
        end
    end
endmodule : ics_partner

// file: verification/ics_sequencer_tb_top.sv
// ics_sequencer_tb_top: directed scenarios for the configuration sequencer.
// assumes ics_partner stands in for flash and config_ram; open-drain lines pulled up.
`timescale 1ns/1ps
module ics_sequencer_tb_top;
    import ics_pkg::*;
    logic clk, resetn, reconfig_req_n, ext_done_low, auto_restart_en, compress_en;
    logic io_config_bits, pin_user_sel, status_out, status_oe, done_out, done_oe;
    logic flash_rd, flash_rvalid, flash_err, config_ram_we, config_ram_ready, stall_en, err_arm;
    logic pin_user_en, user_mode, config_error;
    logic [FADDR_W-1:0] flash_addr;
    logic [31:0]        flash_rdata;
    logic [3:0]         lat;
    ics_config_ram_wr_t       config_ram_wr;
    ics_io_mode_t       io_mode;
    logic               status_line, done_line;
    int                 mismatches, num_checks, cycles;

    // open-drain wires with pull-ups; the bench may hold done low itself
    assign status_line = ~status_oe;
    assign done_line   = ~(done_oe | ext_done_low);

    ics_sequencer dut_u (.clk(clk), .resetn(resetn), .reconfig_req_n(reconfig_req_n),
        .status_in(status_line), .status_out(status_out), .status_oe(status_oe),
        .done_in(done_line), .done_out(done_out), .done_oe(done_oe),
        .auto_restart_en(auto_restart_en), .compress_en(compress_en),
        .io_config_bits(io_config_bits), .pin_user_sel(pin_user_sel),
        .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_rvalid(flash_rvalid),
        .flash_err(flash_err), .flash_rdata(flash_rdata), .config_ram_we(config_ram_we),
        .config_ram_wr(config_ram_wr), .config_ram_ready(config_ram_ready), .io_mode(io_mode),
        .pin_user_en(pin_user_en), .user_mode(user_mode), .config_error(config_error));

    ics_partner flash_u (.clk(clk), .resetn(resetn), .flash_rd(flash_rd),
        .flash_addr(flash_addr), .flash_rvalid(flash_rvalid), .flash_err(flash_err),
        .flash_rdata(flash_rdata), .config_ram_we(config_ram_we), .config_ram_wr(config_ram_wr),
        .config_ram_ready(config_ram_ready), .lat(lat), .stall_en(stall_en), .err_arm(err_arm));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic put_img(input logic [31:0] img[$]);
        foreach (img[i]) flash_u.mem[i] = img[i];
    endtask : put_img

    task automatic wait_user();
        int n;
        n = 0;
        while (user_mode !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
        check(user_mode, 1'b1);
    endtask : wait_user

    task automatic wait_error();
        int n;
        n = 0;
        while (config_error !== 1'b1 && n < 600) begin
            tick(1);
            n++;
        end
    endtask : wait_error

    task automatic check_ram(input logic [15:0] exp[$], input int base);
        check(flash_u.wr_cnt - base, exp.size());
        foreach (exp[i]) check(flash_u.ram[i], exp[i]);
    endtask : check_ram

    // request held low well past the synchronizer
    task automatic pulse_req(input ics_io_mode_t m);
        @(posedge clk);
        reconfig_req_n <= 1'b0;
        tick(8);
        check(status_oe, 1'b1);
        check(done_oe, 1'b1);
        check(io_mode, m);
        check(user_mode, 1'b0);
        check({status_out, done_out}, 2'h0);
        @(posedge clk);
        reconfig_req_n <= 1'b1;
    endtask : pulse_req

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_power_up();
        int n;
        put_img('{32'h0000_0003, 32'h0000_1234, 32'h0000_5678, 32'h0000_9ABC});
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        tick(50);
        check(flash_rd, 1'b0);
        n = 0;
        while (done_oe !== 1'b0 && n < 2000) begin
            tick(1);
            n++;
        end
        check(flash_u.wr_cnt, 3);
        tick(40);
        check(user_mode, 1'b0);
        check(pin_user_en, 1'b0);
        @(posedge clk);
        ext_done_low <= 1'b0;
        tick(60);
        check(user_mode, 1'b0);
        wait_user();
        check_ram('{16'h1234, 16'h5678, 16'h9ABC}, 0);
        check(io_mode, IO_USER);
        check(pin_user_en, 1'b1);
    endtask : s_power_up

    task automatic s_refuse_run();
        int base;
        put_img('{32'h0000_0002, 32'h8001_5555});
        pulse_req(IO_PULLUP);
        wait_error();
        check(status_oe, 1'b1);
        check(status_line, 1'b0);
        tick(120);
        check(config_error, 1'b1);
        check(user_mode, 1'b0);
        put_img('{32'h0000_0007, 32'h0000_1111, 32'h8003_ABCD, 32'h0000_2222,
                  32'h8000_3333});
        @(posedge clk);
        compress_en    <= 1'b1;
        lat            <= 4'h3;
        stall_en       <= 1'b1;
        io_config_bits <= 1'b0;
        base = flash_u.wr_cnt;
        pulse_req(IO_TRISTATE);
        wait_user();
        check_ram('{16'h1111, 16'hABCD, 16'hABCD, 16'hABCD, 16'hABCD, 16'h2222,
                    16'h3333}, base);
        check(config_error, 1'b0);
    endtask : s_refuse_run

    task automatic s_auto_restart();
        int base;
        put_img('{32'h0000_0002, 32'h0000_00AA, 32'h0000_00BB});
        @(posedge clk);
        auto_restart_en <= 1'b1;
        pin_user_sel    <= 1'b0;
        err_arm         <= 1'b1;
        lat             <= 4'h0;
        stall_en        <= 1'b0;
        base = flash_u.wr_cnt;
        pulse_req(IO_TRISTATE);
        wait_error();
        check(config_error, 1'b1);
        check(status_oe, 1'b1);
        @(posedge clk);
        err_arm <= 1'b0;
        wait_user();
        check_ram('{16'h00AA, 16'h00BB}, base);
        check(pin_user_en, 1'b0);
    endtask : s_auto_restart

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        resetn          = 1'b0;
        reconfig_req_n  = 1'b1;
        ext_done_low    = 1'b1;
        auto_restart_en = 1'b0;
        compress_en     = 1'b0;
        io_config_bits  = 1'b1;
        pin_user_sel    = 1'b1;
        lat             = 4'h0;
        stall_en        = 1'b0;
        err_arm         = 1'b0;
        mismatches      = 0;
        num_checks      = 0;
        s_power_up();
        s_refuse_run();
        s_auto_restart();
        results();
    end

    initial begin
        cycles = 0;
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles == 20000) begin
                mismatches++;
                results();
            end
        end
    end
endmodule : ics_sequencer_tb_top
